/* File: common/mult_pkg.sv */
// constants and carrier types for the shift-add multiplier
package mult_pkg;

  // register byte addresses
  localparam logic [15:0] ADDR_PRODUCT_LO = 16'hffd0;
  localparam logic [15:0] ADDR_PRODUCT_HI = 16'hffd1;
  localparam logic [15:0] ADDR_CONTROL    = 16'hffd2;
  localparam logic [15:0] ADDR_OPERAND_A  = 16'hffd4;
  localparam logic [15:0] ADDR_OPERAND_B  = 16'hffd5;

  // field positions and reset values
  localparam int unsigned RUN_BIT_POS   = 0;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [15:0] RDATA_RESET   = 16'h0000;

  // step counter limits
  localparam logic [2:0]  STEP_FIRST = 3'h0;
  localparam logic [2:0]  STEP_LAST  = 3'h7;

  // clock rate and operation length
  localparam int unsigned CLK_PERIOD_NS  = 50;
  localparam int unsigned OP_CLOCKS      = 16;
  localparam logic [4:0]  OP_CLOCKS_5B   = 5'h10;

  // one access from the cpu memory port
  typedef struct packed {
    logic        wr;      // byte or word write
    logic        bit_wr;  // single-bit write
    logic        wide;    // 16-bit access at even address
    logic [15:0] addr;
    logic [15:0] wdata;
    logic [2:0]  bit_sel;
    logic        bit_val;
  } bus_req_type;

  // internal engine state
  typedef struct packed {
    logic [2:0] cnt;
    logic       phase;
    logic       done;
  } step_state_type;

endpackage

/* File: tb/testbench.sv */
`timescale 1ns/100ps
// self-checking bench for the shift-add multiplier register interface
module testbench;
  import mult_pkg::*;

  logic        i_clk_sys;
  logic        i_rst_n;
  logic        i_ce;
  bus_req_type i_bus;
  logic [15:0] o_rdata;
  logic        o_run;
  int          n_mismatch;
  int          n_compared;
  logic [7:0]  ta [5];
  logic [7:0]  tb [5];
  logic [15:0] prod;

  mult_core dut (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .i_bus     (i_bus),
    .o_rdata   (o_rdata),
    .o_run     (o_run)
  );

  // 50 ns clock
  always #(CLK_PERIOD_NS / 2) i_clk_sys = ~i_clk_sys;

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // byte or word write; a spare idle edge keeps strobes one pulse long
  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic w);
    @(posedge i_clk_sys);
    i_bus <= '{wr: 1'b1, bit_wr: 1'b0, wide: w, addr: a, wdata: d,
               bit_sel: 3'h0, bit_val: 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '0;
  endtask

  task automatic bit_wr(input logic [2:0] sel, input logic val);
    @(posedge i_clk_sys);
    i_bus <= '{wr: 1'b0, bit_wr: 1'b1, wide: 1'b0, addr: ADDR_CONTROL,
               wdata: 16'h0000, bit_sel: sel, bit_val: val};
    @(posedge i_clk_sys);
    i_bus <= '0;
  endtask

  // read data is registered: address sampled on one edge, data after it
  task automatic rd_chk(input logic [15:0] a, input logic w,
                        input logic [15:0] exp);
    @(posedge i_clk_sys);
    i_bus <= '{wr: 1'b0, bit_wr: 1'b0, wide: w, addr: a, wdata: 16'h0000,
               bit_sel: 3'h0, bit_val: 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '0;
    #1;
    chk(o_rdata, exp);
  endtask

  task automatic run_chk(input logic exp);
    #1;
    chk({15'h0000, o_run}, {15'h0000, exp});
  endtask

  // watchdog: whole sequence needs well under 2000 clocks
  initial begin
    repeat (5000) @(posedge i_clk_sys);
    n_mismatch++;
    conclude();
  end

  initial begin
    i_clk_sys = 1'b0;
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_bus = '0;
    n_mismatch = 0;
    n_compared = 0;
    ta = '{8'haa, 8'hff, 8'h00, 8'h01, 8'h80};
    tb = '{8'hd3, 8'hff, 8'h5a, 8'h80, 8'h01};
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    run_chk(1'b0);
    rd_chk(ADDR_CONTROL, 1'b0, 16'h0000);
    // operand and product registers read back by byte and word
    wr(ADDR_OPERAND_A, 16'h005c, 1'b0);
    rd_chk(ADDR_OPERAND_A, 1'b0, 16'h005c);
    wr(ADDR_PRODUCT_HI, 16'h00a5, 1'b0);
    wr(ADDR_PRODUCT_LO, 16'h003c, 1'b0);
    rd_chk(ADDR_PRODUCT_LO, 1'b1, 16'ha53c);
    // upper control bits are written zero and read as zero
    wr(ADDR_CONTROL, 16'h0000, 1'b0);
    rd_chk(ADDR_CONTROL, 1'b0, 16'h0000);
    run_chk(1'b0);
    for (int i = 0; i < 5; i++) begin
      prod = {8'h00, ta[i]} * {8'h00, tb[i]};
      wr(ADDR_OPERAND_A, {8'h00, ta[i]}, 1'b0);
      wr(ADDR_OPERAND_B, {8'h00, tb[i]}, 1'b0);
      wr(ADDR_PRODUCT_LO, 16'h0000, 1'b1);
      // alternate byte write and single-bit write as the start
      if (i[0]) begin
        bit_wr(3'h0, 1'b1);
      end else begin
        wr(ADDR_CONTROL, 16'h0001, 1'b0);
      end
      run_chk(1'b1);
      repeat (OP_CLOCKS) @(posedge i_clk_sys);
      rd_chk(ADDR_PRODUCT_LO, 1'b1, prod);
      rd_chk(ADDR_PRODUCT_HI, 1'b0, {8'h00, prod[15:8]});
      rd_chk(ADDR_CONTROL, 1'b0, 16'h0001);
      bit_wr(3'h0, 1'b0);
      run_chk(1'b0);
      rd_chk(ADDR_PRODUCT_LO, 1'b1, prod);
    end
    // restart after a stop: counter must start again from zero
    wr(ADDR_PRODUCT_LO, 16'h0000, 1'b1);
    wr(ADDR_CONTROL, 16'h0001, 1'b0);
    repeat (OP_CLOCKS) @(posedge i_clk_sys);
    rd_chk(ADDR_PRODUCT_LO, 1'b1, 16'h0080);
    // reset in mid-run clears the control register and status
    wr(ADDR_CONTROL, 16'h0000, 1'b0);
    wr(ADDR_CONTROL, 16'h0001, 1'b0);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    run_chk(1'b0);
    rd_chk(ADDR_CONTROL, 1'b0, 16'h0000);
    conclude();
  end
endmodule

/* File: verilog/mult_core.sv */
`timescale 1ns/100ps
// sequential 8x8 unsigned shift-add multiplier with its registers
//
// Summary of operation
// RULE1 - multiply two 8-bit operands to 16 bits
// RULE2 - operands come from operand a and b
// RULE3 - product valid 16 clocks after start
// RULE4 - product register has no reset value
// RULE5 - operand registers have no reset value
// RULE6 - product accepts word or byte access
// RULE7 - control at ffd2, 8 bits, resets 00
// RULE8 - software writes zero to control bits 1-7
// RULE9 - setting run bit starts the counter
// RULE10 - each step adds selector, counter plus one
// RULE11 - clearing run at count 7 stops, holds product
// RULE12 - run low keeps counter and slave cleared
// RULE13 - run bit reads back as busy status
// RULE14 - selector gives a shifted when b bit set
module mult_core
  import mult_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire bus_req_type i_bus,
  output logic      [15:0] o_rdata,
  output logic             o_run
);

  // register state
  logic [7:0]     operand_a_q;
  logic [7:0]     operand_b_q;
  logic [15:0]    product_q;
  logic           run_bit_q;
  logic [15:0]    slave_q;
  step_state_type step_q;
  logic [15:0]    rdata_q;

  // address decode
  wire logic hit_lo   = (i_bus.addr == ADDR_PRODUCT_LO);
  wire logic hit_hi   = (i_bus.addr == ADDR_PRODUCT_HI);
  wire logic hit_ctl  = (i_bus.addr == ADDR_CONTROL);
  wire logic hit_a    = (i_bus.addr == ADDR_OPERAND_A);
  wire logic hit_b    = (i_bus.addr == ADDR_OPERAND_B);
  wire logic any_wr   = i_bus.wr & i_ce;

  // a word access at the low address covers both product bytes
  wire logic wr_lo    = any_wr & hit_lo;                            // RULE6
  wire logic wr_hi    = any_wr & ((hit_lo & i_bus.wide) | hit_hi);  // RULE6
  wire logic wr_a     = any_wr & hit_a;                             // RULE2
  wire logic wr_b     = any_wr & hit_b;                             // RULE2
  wire logic wr_ctl   = any_wr & hit_ctl;                           // RULE7
  wire logic bwr_ctl  = i_bus.bit_wr & i_ce & hit_ctl &
                        (i_bus.bit_sel == 3'(RUN_BIT_POS));         // RULE7
  wire logic [7:0] hi_wdata = (hit_lo & i_bus.wide) ?
                              i_bus.wdata[15:8] : i_bus.wdata[7:0];

  // only the run bit is stored; bits 1-7 are expected to be written 0
  wire logic run_bit_d = wr_ctl  ? i_bus.wdata[RUN_BIT_POS] :     // RULE8
                         bwr_ctl ? i_bus.bit_val : run_bit_q;

  // engine stepping
  wire logic        stepping  = run_bit_q & ~step_q.done;           // RULE9
  wire logic        add_now   = stepping & step_q.phase;            // RULE10
  wire logic        last_step = step_q.cnt == STEP_LAST;            // RULE11
  logic      [15:0] partial;
  wire logic [15:0] sum       = product_q + slave_q;                // RULE1

  mult_selector u_selector (
    .i_operand_a (operand_a_q),
    .i_operand_b (operand_b_q),
    .i_step      (step_q.cnt),
    .o_partial   (partial)
  );

  // next engine state; run low forces counter, phase and slave clear
  step_state_type step_d;
  // clearing follows the next run value so status 0 already shows count 0
  wire logic [15:0] slave_d = !run_bit_d ? 16'h0000 :               // RULE12
                              (stepping & ~step_q.phase) ? partial :
                              slave_q;
  always_comb begin
    step_d = step_q;
    if (!run_bit_d) begin
      step_d.cnt   = STEP_FIRST;                                    // RULE12
      step_d.phase = 1'b0;
      step_d.done  = 1'b0;
    end else if (stepping) begin
      step_d.phase = ~step_q.phase;
      if (step_q.phase) begin
        // counter stops at 7 and done ends stepping, so the product cannot keep growing
        step_d.cnt  = last_step ? STEP_LAST : step_q.cnt + 3'h1;    // RULE10
        step_d.done = last_step;                                    // RULE3
      end
    end
  end

  // product: engine has priority over a software write while running
  wire logic [15:0] product_d = add_now ? sum :                     // RULE10
                                {wr_hi ? hi_wdata : product_q[15:8],
                                 wr_lo ? i_bus.wdata[7:0] :
                                         product_q[7:0]};           // RULE6

  // read mux, registered so data reaches the bus from a flip-flop
  wire logic [15:0] rd_mux =
    hit_lo  ? (i_bus.wide ? product_q : {8'h00, product_q[7:0]}) :
    hit_hi  ? {8'h00, product_q[15:8]} :
    hit_ctl ? {15'h0000, run_bit_q} :                               // RULE13
    hit_a   ? {8'h00, operand_a_q} :
    hit_b   ? {8'h00, operand_b_q} : RDATA_RESET;

  // control and engine state, cleared by reset
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_bit_q <= CONTROL_RESET[RUN_BIT_POS];                      // RULE7
      step_q    <= '0;
      slave_q   <= 16'h0000;
      rdata_q   <= RDATA_RESET;
    end else if (i_ce) begin
      run_bit_q <= run_bit_d;
      step_q    <= step_d;
      slave_q   <= slave_d;
      rdata_q   <= rd_mux;
    end
  end

  // data registers carry no reset: their contents start undefined
  always_ff @(posedge i_clk_sys) begin
    if (i_ce) begin
      product_q <= product_d;                                       // RULE4
      if (wr_a) begin
        operand_a_q <= i_bus.wdata[7:0];                            // RULE5
      end
      if (wr_b) begin
        operand_b_q <= i_bus.wdata[7:0];                            // RULE5
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_run   = run_bit_q;                                       // RULE13

  // helper: enabled stepping cycles since the run bit was set, held once done
  logic [4:0] op_clk_q;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_clk_q <= 5'h00;
    end else if (i_ce) begin
      op_clk_q <= !run_bit_q ? 5'h00 :
                  stepping ? op_clk_q + 5'h01 : op_clk_q;
    end
  end

  // helper: expected product of the operands
  wire logic [15:0] ref_product = 16'(operand_a_q) * 16'(operand_b_q);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  op_length_a: assert property (                                   // RULE3
    $rose(step_q.done) |-> op_clk_q == OP_CLOCKS_5B)
    else $error("operation did not end after 16 clocks");

  run_low_clear_a: assert property (                               // RULE12
    !run_bit_q |-> step_q.cnt == STEP_FIRST && slave_q == 16'h0000)
    else $error("counter or slave not cleared while run low");

  start_count_a: assert property (                                 // RULE9
    i_ce && $rose(run_bit_q) ##1 i_ce |=> step_q.phase == 1'b0 &&
    step_q.cnt == 3'h1 && !step_q.done)
    else $error("run bit did not start stepping");

  step_incr_a: assert property (                                   // RULE10
    i_ce && add_now && !last_step |=> step_q.cnt == $past(step_q.cnt)
    + 3'h1)
    else $error("counter did not advance on add");

  step_add_a: assert property (                                    // RULE10
    i_ce && add_now |=> product_q == $past(product_q) + $past(slave_q))
    else $error("product did not take selector sum");

  hold_after_a: assert property (                                  // RULE11
    step_q.done && !(i_ce && (wr_lo || wr_hi)) |=>
    product_q == $past(product_q))
    else $error("product changed after stopping");

  stop_clear_a: assert property (                                  // RULE11
    i_ce && run_bit_q && !run_bit_d |=> !o_run && step_q.cnt == 3'h0)
    else $error("clearing run did not stop the counter");

  ctl_read_a: assert property (                                    // RULE13
    i_ce && hit_ctl && !i_bus.wr && !i_bus.bit_wr |=>
    o_rdata == {15'h0000, $past(run_bit_q)})
    else $error("control read does not show run status");

  select_a: assert property (                                      // RULE14
    run_bit_q && !operand_b_q[step_q.cnt] |-> partial == 16'h0000)
    else $error("selector not zero for clear b bit");

  product_a: assert property (                                     // RULE1
    i_ce && stepping && step_q.cnt == STEP_FIRST && !step_q.phase &&
    product_q == 16'h0000 ##1 (i_ce && run_bit_q &&
    !(wr_a || wr_b || wr_lo || wr_hi)) [*8] ##1
    (i_ce && run_bit_q && !(wr_a || wr_b || wr_lo || wr_hi)) [*8]
    |-> product_q == ref_product)
    else $error("product differs from a times b");

  cv_start_c: cover property ($rose(run_bit_q));
  cv_done_c:  cover property ($rose(step_q.done));
  cv_stop_c:  cover property (step_q.done ##1 !run_bit_q);
  cv_word_c:  cover property (i_ce && i_bus.wr && i_bus.wide && hit_lo);
  cv_bit_c:   cover property (i_ce && bwr_ctl && i_bus.bit_val);

  // register writes: each byte lands where its address says

  operand_a_wr_a: assert property (                                // RULE2
    i_ce && wr_a |=> operand_a_q == $past(i_bus.wdata[7:0]))
    else $error("operand a write did not land");

  operand_b_wr_a: assert property (                                // RULE2
    i_ce && wr_b |=> operand_b_q == $past(i_bus.wdata[7:0]))
    else $error("operand b write did not land");

  // product writes only land when the engine is not adding
  prod_lo_wr_a: assert property (                                  // RULE6
    i_ce && wr_lo && !add_now |=>
    product_q[7:0] == $past(i_bus.wdata[7:0]))
    else $error("product low byte write did not land");

  prod_hi_wr_a: assert property (                                  // RULE6
    i_ce && wr_hi && !add_now |=> product_q[15:8] == $past(hi_wdata))
    else $error("product high byte write did not land");

  // a word read returns both product bytes in one access
  word_read_a: assert property (                                   // RULE6
    i_ce && hit_lo && i_bus.wide && !i_bus.wr |=>
    o_rdata == $past(product_q))
    else $error("word read of product wrong");

  // control register: byte write and single-bit write both set run
  ctl_byte_wr_a: assert property (                                 // RULE7
    i_ce && wr_ctl |=> run_bit_q == $past(i_bus.wdata[RUN_BIT_POS]))
    else $error("control byte write did not set run bit");

  ctl_bit_wr_a: assert property (                                  // RULE7
    i_ce && bwr_ctl && !wr_ctl |=> run_bit_q == $past(i_bus.bit_val))
    else $error("control bit write did not set run bit");

  // bit writes to the unused control bits must leave run alone
  ctl_other_a: assert property (                                   // RULE7
    i_ce && i_bus.bit_wr && hit_ctl && !bwr_ctl && !wr_ctl |=>
    run_bit_q == $past(run_bit_q))
    else $error("unused control bit write changed run bit");

  // stopped engine keeps phase and done flag cleared as well
  phase_clear_a: assert property (                                 // RULE12
    !run_bit_q |-> !step_q.phase && !step_q.done)
    else $error("phase or done left set while run low");

  // once done, the counter sits at its last value until run drops
  done_hold_a: assert property (                                   // RULE11
    i_ce && step_q.done && run_bit_d |=>
    step_q.done && step_q.cnt == STEP_LAST)
    else $error("counter moved after the last step");

  // a frozen clock enable must leave all visible state alone
  ce_freeze_a: assert property (
    !i_ce |=> run_bit_q == $past(run_bit_q) &&
    step_q == $past(step_q) && o_rdata == $past(o_rdata))
    else $error("state changed while clock enable low");

  // unmapped addresses read as zero so software sees no stale data
  unmapped_rd_a: assert property (
    i_ce && !(hit_lo || hit_hi || hit_ctl || hit_a || hit_b) |=>
    o_rdata == RDATA_RESET)
    else $error("unmapped address did not read zero");

endmodule

/* File: verilog/mult_selector.sv */
`timescale 1ns/100ps
// partial product selector: operand a shifted by step, gated by b bit
module mult_selector
  import mult_pkg::*;
(
  input  wire logic [7:0]  i_operand_a,
  input  wire logic [7:0]  i_operand_b,
  input  wire logic [2:0]  i_step,
  output logic      [15:0] o_partial
);

  // zero-extend first so the shift keeps every bit of the product
  wire logic [15:0] a_wide    = {8'h00, i_operand_a};
  wire logic        b_sel_bit = i_operand_b[i_step];

  assign o_partial = b_sel_bit ? (a_wide << i_step) : 16'h0000; // RULE14

endmodule
